//--- design/rscc_top.sv
// Strap capture at master reset, pointers, flags and APB register access
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

// Function
// - Sample offset select straps during master reset
// - Load chosen preset into both flag offsets
// - Sample fall-through select; high means fall-through
// - Cascade select high inverts full/input-ready output in standard mode only
// - Port widths come from port width straps
// - Master reset clears pointers, output register, applies settings
// - Standard mode shows full; fall-through shows space
// - Almost-full high while free exceeds full offset
module rscc_top (
  input wire logic clk,
  input wire logic nrst,
  // Board straps and reset pin, asynchronous to clk
  input wire logic master_reset_in_n,
  input wire logic [1:0] default_offset_select,
  input wire logic fall_through_mode_select,
  input wire logic depth_cascade_polarity_select,
  input wire logic [3:0] port_width_select,
  // Data path strobes on clk
  input wire logic write_req,
  input wire logic read_req,
  // Settings and flags toward the data path and pins
  output logic [rscc_pkg::ADDR_W-1:0] wr_addr,
  output logic [rscc_pkg::ADDR_W-1:0] rd_addr,
  output logic write_accept,
  output logic read_accept,
  output logic out_reg_clear,
  output logic fall_through_mode,
  output logic [1:0] write_width,
  output logic [1:0] read_width,
  output logic full_or_input_ready,
  output logic almost_full_flag,
  output logic almost_empty_flag,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rscc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam logic [rscc_pkg::SYNC_W-1:0] SYNC_INIT = 9'h001;

  logic [rscc_pkg::SYNC_W-1:0] pins_raw;   // Packed strap lanes
  logic [rscc_pkg::SYNC_W-1:0] pins_s;     // Synchronised lanes

  assign pins_raw = {port_width_select, depth_cascade_polarity_select,
                     fall_through_mode_select, default_offset_select,
                     master_reset_in_n};

  // Master reset idles high so a quiet pin does not trigger capture
  rscc_sync #(
    .W(rscc_pkg::SYNC_W),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rscc_pkg::rscc_state_t state_q, state_d;  // Capture state
  logic soft_mrs_q, soft_mrs_d;             // Software master reset pulse
  logic mrs_active;                         // Pin or software reset
  logic [1:0] ofs_sel_q, ofs_sel_d;         // Latched offset select
  logic fall_through_mode_select_q, fall_through_mode_select_d;                     // Latched timing mode
  logic casc_q, casc_d;                     // Latched cascade polarity
  logic [3:0] pw_q, pw_d;                   // Latched port width code
  logic [1:0] wrw_q, wrw_d;                 // Decoded write width
  logic [1:0] rdw_q, rdw_d;                 // Decoded read width
  logic [rscc_pkg::OFS_W-1:0] ae_ofs_q, ae_ofs_d;
  logic [rscc_pkg::OFS_W-1:0] af_ofs_q, af_ofs_d;
  logic [rscc_pkg::OFS_W-1:0] preset;       // Preset picked by straps
  logic [rscc_pkg::CNT_W-1:0] wr_ptr_q, wr_ptr_d;
  logic [rscc_pkg::CNT_W-1:0] rd_ptr_q, rd_ptr_d;
  logic [rscc_pkg::CNT_W-1:0] count;        // Words held
  logic [rscc_pkg::CNT_W-1:0] free_cnt;     // Free locations
  logic is_full, is_empty;
  logic wr_ok, rd_ok;
  logic wacc_q, wacc_d, racc_q, racc_d;
  logic clr_q, clr_d;
  logic fir_q, fir_d, af_q, af_d, ae_q, ae_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] rd_word;                     // Read mux result
  logic rd_hit;                             // Address is mapped
  logic apb_wr;                             // Write takes effect now

  // Decode one two-bit width field; the unused code falls back to x36
  function automatic logic [1:0] width_of(input logic [1:0] code);
    logic [1:0] w;
    w = rscc_pkg::RSCC_W36;
    unique case (code)
      rscc_pkg::PW_CODE_18: w = rscc_pkg::RSCC_W18;
      rscc_pkg::PW_CODE_9: w = rscc_pkg::RSCC_W9;
      default: w = rscc_pkg::RSCC_W36;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Capture state machine and latched settings
  // ----------------------------------------------------------------
  assign mrs_active = !pins_s[rscc_pkg::SY_MRS] || soft_mrs_q;
  assign apb_wr = psel && penable && pready_q && pwrite;

  // Preset lookup from the live straps
  always_comb begin
    preset = rscc_pkg::OFFSET_PRESET0;
    unique case (pins_s[rscc_pkg::SY_OFS_LO +: 2])
      2'h0: preset = rscc_pkg::OFFSET_PRESET0;
      2'h1: preset = rscc_pkg::OFFSET_PRESET1;
      2'h2: preset = rscc_pkg::OFFSET_PRESET2;
      2'h3: preset = rscc_pkg::OFFSET_PRESET3;
    endcase
  end

  // Next state and settings; straps are copied only while reset acts
  always_comb begin
    state_d = state_q;
    ofs_sel_d = ofs_sel_q;
    fall_through_mode_select_d = fall_through_mode_select_q;
    casc_d = casc_q;
    pw_d = pw_q;
    wrw_d = wrw_q;
    rdw_d = rdw_q;
    ae_ofs_d = ae_ofs_q;
    af_ofs_d = af_ofs_q;
    soft_mrs_d = 1'b0;
    // Software reset is a one-cycle request from the control register
    if (apb_wr && paddr == rscc_pkg::REG_CTRL) begin
      soft_mrs_d = pwdata[rscc_pkg::CTRL_SOFT_MRS];
    end
    // Offsets are writable in service; master reset overrides a write
    if (apb_wr && paddr == rscc_pkg::REG_AE_OFS) begin
      ae_ofs_d = pwdata[rscc_pkg::OFS_W-1:0];
    end
    if (apb_wr && paddr == rscc_pkg::REG_AF_OFS) begin
      af_ofs_d = pwdata[rscc_pkg::OFS_W-1:0];
    end
    if (mrs_active) begin
      state_d = rscc_pkg::RSCC_CAPT;
      ofs_sel_d = pins_s[rscc_pkg::SY_OFS_LO +: 2];
      ae_ofs_d = preset;
      af_ofs_d = preset;
      fall_through_mode_select_d = pins_s[rscc_pkg::SY_FALL_THROUGH_MODE_SELECT];
      casc_d = pins_s[rscc_pkg::SY_CASC];
      pw_d = pins_s[rscc_pkg::SY_PW_LO +: 4];
      wrw_d = width_of(pins_s[rscc_pkg::SY_PW_LO +: 2]);
      rdw_d = width_of(pins_s[rscc_pkg::SY_PW_LO + 2 +: 2]);
    end else begin
      unique case (state_q)
        rscc_pkg::RSCC_IDLE: state_d = rscc_pkg::RSCC_IDLE;
        rscc_pkg::RSCC_CAPT: state_d = rscc_pkg::RSCC_RUN;
        rscc_pkg::RSCC_RUN: state_d = rscc_pkg::RSCC_RUN;
        default: state_d = rscc_pkg::RSCC_IDLE;
      endcase
    end
  end

  // Register state and settings
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= rscc_pkg::RSCC_IDLE;
      soft_mrs_q <= 1'b0;
      ofs_sel_q <= 2'h0;
      fall_through_mode_select_q <= 1'b0;
      casc_q <= 1'b0;
      pw_q <= 4'h0;
      wrw_q <= rscc_pkg::RSCC_W36;
      rdw_q <= rscc_pkg::RSCC_W36;
      ae_ofs_q <= rscc_pkg::OFFSET_RESET;
      af_ofs_q <= rscc_pkg::OFFSET_RESET;
    end else begin
      state_q <= state_d;
      soft_mrs_q <= soft_mrs_d;
      ofs_sel_q <= ofs_sel_d;
      fall_through_mode_select_q <= fall_through_mode_select_d;
      casc_q <= casc_d;
      pw_q <= pw_d;
      wrw_q <= wrw_d;
      rdw_q <= rdw_d;
      ae_ofs_q <= ae_ofs_d;
      af_ofs_q <= af_ofs_d;
    end
  end

  // ----------------------------------------------------------------
  // Pointers, count and flags
  // ----------------------------------------------------------------
  assign count = wr_ptr_q - rd_ptr_q;
  assign free_cnt = rscc_pkg::DEPTH - count;
  assign is_full = (count == rscc_pkg::DEPTH);
  assign is_empty = (count == '0);
  // Nothing moves before the first master reset has set the mode
  assign wr_ok = write_req && !is_full && state_q == rscc_pkg::RSCC_RUN;
  assign rd_ok = read_req && !is_empty && state_q == rscc_pkg::RSCC_RUN;

  // Next pointers and flag levels; flags follow the count one cycle late
  always_comb begin
    wr_ptr_d = wr_ptr_q + (wr_ok ? 11'h001 : 11'h000);
    rd_ptr_d = rd_ptr_q + (rd_ok ? 11'h001 : 11'h000);
    wacc_d = wr_ok;
    racc_d = rd_ok;
    clr_d = 1'b0;
    af_d = (free_cnt > {1'b0, af_ofs_q});
    ae_d = (count > {1'b0, ae_ofs_q});
    if (fall_through_mode_select_q) begin
      fir_d = is_full;    // Input-ready low while space remains
    end else begin
      fir_d = !is_full;   // Full flag low when memory is full
    end
    if (casc_q && !fall_through_mode_select_q) begin
      fir_d = !fir_d;
    end
    if (mrs_active) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      wacc_d = 1'b0;
      racc_d = 1'b0;
      clr_d = 1'b1;
    end
  end

  // Register pointers and flag outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      wacc_q <= 1'b0;
      racc_q <= 1'b0;
      clr_q <= 1'b1;
      fir_q <= 1'b1;
      af_q <= 1'b1;
      ae_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      wacc_q <= wacc_d;
      racc_q <= racc_d;
      clr_q <= clr_d;
      fir_q <= fir_d;
      af_q <= af_d;
      ae_q <= ae_d;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: read data latched in setup, one access cycle always
  // ----------------------------------------------------------------
  // Read mux; the register file is small enough to decode flat
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      rscc_pkg::REG_CTRL: rd_word = 32'h0000_0000;
      rscc_pkg::REG_CFG: begin
        rd_word[rscc_pkg::CFG_OFS_LO +: 2] = ofs_sel_q;
        rd_word[rscc_pkg::CFG_FALL_THROUGH_MODE_SELECT] = fall_through_mode_select_q;
        rd_word[rscc_pkg::CFG_CASC] = casc_q;
        rd_word[rscc_pkg::CFG_PW_LO +: 4] = pw_q;
        rd_word[rscc_pkg::CFG_WRW_LO +: 2] = wrw_q;
        rd_word[rscc_pkg::CFG_RDW_LO +: 2] = rdw_q;
        rd_word[rscc_pkg::CFG_VALID] = (state_q == rscc_pkg::RSCC_RUN);
      end
      rscc_pkg::REG_AE_OFS: rd_word[rscc_pkg::OFS_W-1:0] = ae_ofs_q;
      rscc_pkg::REG_AF_OFS: rd_word[rscc_pkg::OFS_W-1:0] = af_ofs_q;
      rscc_pkg::REG_LEVEL: begin
        rd_word[rscc_pkg::CNT_W-1:0] = count;
        rd_word[rscc_pkg::LVL_FULL] = is_full;
        rd_word[rscc_pkg::LVL_EMPTY] = is_empty;
        rd_word[rscc_pkg::LVL_AF] = af_q;
        rd_word[rscc_pkg::LVL_AE] = ae_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer is prepared at the setup edge so outputs stay flop-driven
  always_comb begin
    pready_d = psel && !penable;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      prdata_d = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_d = !rd_hit;
    end
  end

  // Register bus answer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign wr_addr = wr_ptr_q[rscc_pkg::ADDR_W-1:0];
  assign rd_addr = rd_ptr_q[rscc_pkg::ADDR_W-1:0];
  assign write_accept = wacc_q;
  assign read_accept = racc_q;
  assign out_reg_clear = clr_q;
  assign fall_through_mode = fall_through_mode_select_q;
  assign write_width = wrw_q;
  assign read_width = rdw_q;
  assign full_or_input_ready = fir_q;
  assign almost_full_flag = af_q;
  assign almost_empty_flag = ae_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule // rscc_top

//--- design/rscc_pkg.sv
// Constants, field layouts and types of the reset strap configuration capture
package rscc_pkg;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;                    // Pointer address width
  localparam int CNT_W = 11;                     // Fill count width
  localparam logic [10:0] DEPTH = 11'h400;       // Locations in memory
  localparam int OFS_W = 10;                     // Flag offset width

  // ----------------------------------------------------------------
  // Preset default offsets chosen by the offset select straps
  // ----------------------------------------------------------------
  localparam logic [9:0] OFFSET_PRESET0 = 10'h007;
  localparam logic [9:0] OFFSET_PRESET1 = 10'h01F;
  localparam logic [9:0] OFFSET_PRESET2 = 10'h03F;
  localparam logic [9:0] OFFSET_PRESET3 = 10'h07F;
  localparam logic [9:0] OFFSET_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Synchroniser lane layout for the pin inputs
  // ----------------------------------------------------------------
  localparam int SYNC_W = 9;
  localparam int SY_MRS = 0;                     // Master reset, low active
  localparam int SY_OFS_LO = 1;                  // Offset select, 2 bits
  localparam int SY_FALL_THROUGH_MODE_SELECT = 3;                    // Fall-through select
  localparam int SY_CASC = 4;                    // Cascade polarity select
  localparam int SY_PW_LO = 5;                   // Port width select, 4 bits

  // ----------------------------------------------------------------
  // Port width encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSCC_W36 = 2'h0,
    RSCC_W18 = 2'h1,
    RSCC_W9 = 2'h2
  } rscc_width_t;
  localparam logic [1:0] PW_CODE_36 = 2'h0;
  localparam logic [1:0] PW_CODE_18 = 2'h1;
  localparam logic [1:0] PW_CODE_9 = 2'h2;

  // ----------------------------------------------------------------
  // Capture state machine, Gray along idle, capture, run
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSCC_IDLE = 2'h0,
    RSCC_CAPT = 2'h1,
    RSCC_RUN = 2'h3
  } rscc_state_t;

  // ----------------------------------------------------------------
  // APB register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;    // W: bit0 soft reset
  localparam logic [11:0] REG_CFG = 12'h004;     // R: latched settings
  localparam logic [11:0] REG_AE_OFS = 12'h008;  // RW: almost-empty offset
  localparam logic [11:0] REG_AF_OFS = 12'h00C;  // RW: almost-full offset
  localparam logic [11:0] REG_LEVEL = 12'h010;   // R: fill and flags
  localparam int CTRL_SOFT_MRS = 0;
  localparam int CFG_OFS_LO = 0;
  localparam int CFG_FALL_THROUGH_MODE_SELECT = 2;
  localparam int CFG_CASC = 3;
  localparam int CFG_PW_LO = 4;
  localparam int CFG_WRW_LO = 8;
  localparam int CFG_RDW_LO = 10;
  localparam int CFG_VALID = 12;
  localparam int LVL_FULL = 16;
  localparam int LVL_EMPTY = 17;
  localparam int LVL_AF = 18;
  localparam int LVL_AE = 19;

endpackage // rscc_pkg

//--- design/rscc_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Each lane passes two flops; only the second flop is read outside
// ----------------------------------------------------------------
module rscc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;   // First stage, may go metastable
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;   // Second stage, safe to use
  logic [W-1:0] sync_d;

  // Next values of both stages
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Register both stages; reset to the idle level of the pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // rscc_sync

//--- tb/rscc_checker.sv
// Port-level assertions for the strap capture block
`timescale 1ns/100ps

module rscc_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic out_reg_clear,
  input wire logic [rscc_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [rscc_pkg::ADDR_W-1:0] rd_addr,
  input wire logic write_accept,
  input wire logic read_accept,
  input wire logic fall_through_mode,
  input wire logic [1:0] write_width,
  input wire logic [1:0] read_width,
  input wire logic full_or_input_ready,
  input wire logic almost_full_flag,
  input wire logic almost_empty_flag,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------------------------------
  // One clock domain, reset disables all
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  cfg_hold_a: assert property ($past(nrst) && !out_reg_clear |->
    $stable({fall_through_mode, write_width, read_width}))
    else $error("settings moved outside master reset");
  ptr_clear_a: assert property (out_reg_clear |->
    wr_addr == '0 && rd_addr == '0)
    else $error("pointer not cleared by master reset");
  no_traffic_a: assert property (out_reg_clear |->
    !write_accept && !read_accept)
    else $error("transfer accepted during master reset");
  wr_step_a: assert property (write_accept |->
    (wr_addr - $past(wr_addr)) == 10'h001)
    else $error("write pointer did not advance by one");
  rd_step_a: assert property (read_accept |->
    (rd_addr - $past(rd_addr)) == 10'h001)
    else $error("read pointer did not advance by one");
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  empty_flags_a: assert property (out_reg_clear[*3] |->
    almost_full_flag && !almost_empty_flag)
    else $error("flags wrong while held cleared");
  ft_space_a: assert property (out_reg_clear[*4] && fall_through_mode |->
    !full_or_input_ready)
    else $error("input ready not shown when empty");
endmodule // rscc_checker

bind rscc_top rscc_checker chk_i (.clk, .nrst, .out_reg_clear, .wr_addr,
  .rd_addr, .write_accept, .read_accept, .fall_through_mode, .write_width,
  .read_width, .full_or_input_ready, .almost_full_flag, .almost_empty_flag,
  .psel, .penable, .pready, .pslverr);

//--- tb/rscc_board_model.sv
// Board straps and master reset source driving the block
`timescale 1ns/100ps

module rscc_board_model (
  input wire logic clk,
  output logic master_reset_in_n,
  output logic [1:0] default_offset_select,
  output logic fall_through_mode_select,
  output logic depth_cascade_polarity_select,
  output logic [3:0] port_width_select
);
  initial begin
    master_reset_in_n = 1'b1;
    default_offset_select = 2'h0;
    fall_through_mode_select = 1'b0;
    depth_cascade_polarity_select = 1'b0;
    port_width_select = 4'h0;
  end

  // Straps settle, reset pulses, straps held past the synced release
  task automatic pulse(input logic [1:0] s, input logic f, input logic c,
                       input logic [3:0] p, input int len);
    @(posedge clk);
    default_offset_select <= s;
    fall_through_mode_select <= f;
    depth_cascade_polarity_select <= c & ~f;
    port_width_select <= p;
    master_reset_in_n <= 1'b0;
    repeat (len) @(posedge clk);
    master_reset_in_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  // Straps moved outside reset, as a careless board might
  task automatic wiggle();
    logic f;
    f = 1'($urandom);
    @(posedge clk);
    default_offset_select <= 2'($urandom);
    fall_through_mode_select <= f;
    depth_cascade_polarity_select <= 1'($urandom) & ~f;
    port_width_select <= 4'($urandom);
  endtask
endmodule // rscc_board_model

//--- tb/rscc_top_bench.sv
// Self-checking bench for the strap capture block
`timescale 1ns/100ps

module rscc_top_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic write_req = 1'b0;
  logic read_req = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic mrs_n, ft_sel, cas_sel, ft, cs, ofr, out_clr, af, ae;
  logic [1:0] ofs_sel, ww, rw;
  logic [3:0] pw_sel;
  logic [9:0] wa, ra;
  logic wacc, racc, ftm, pready, pslverr;
  logic [31:0] prdata, rd;
  logic er;
  int error_cnt = 0;
  int total_checks = 0;
  int acc;

  always #12.5 clk = ~clk;

  rscc_board_model brd (.clk(clk), .master_reset_in_n(mrs_n),
    .default_offset_select(ofs_sel), .fall_through_mode_select(ft_sel),
    .depth_cascade_polarity_select(cas_sel), .port_width_select(pw_sel));

  rscc_top uut (.clk(clk), .nrst(nrst), .master_reset_in_n(mrs_n),
    .default_offset_select(ofs_sel), .fall_through_mode_select(ft_sel),
    .depth_cascade_polarity_select(cas_sel), .port_width_select(pw_sel),
    .write_req(write_req), .read_req(read_req), .wr_addr(wa),
    .rd_addr(ra), .write_accept(wacc), .read_accept(racc),
    .out_reg_clear(out_clr), .fall_through_mode(ftm), .write_width(ww),
    .read_width(rw), .full_or_input_ready(ofr), .almost_full_flag(af),
    .almost_empty_flag(ae), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Width decode: code 3 falls back to the widest port
  function automatic logic [1:0] wdec(input logic [1:0] c);
    return (c == 2'h3) ? rscc_pkg::PW_CODE_36 : c;
  endfunction

  function automatic logic [31:0] ecfg(input logic [1:0] s, input logic f,
                                       input logic c, input logic [3:0] p);
    return {19'h0, 1'b1, wdec(p[3:2]), wdec(p[1:0]), p, c, f, s};
  endfunction

  function automatic logic [9:0] preset(input logic [1:0] s);
    case (s)
      2'h0: return rscc_pkg::OFFSET_PRESET0;
      2'h1: return rscc_pkg::OFFSET_PRESET1;
      2'h2: return rscc_pkg::OFFSET_PRESET2;
      default: return rscc_pkg::OFFSET_PRESET3;
    endcase
  endfunction

  // APB transfer; every change follows a rising edge, wait is bounded
  // Leading edge keeps a second call from re-driving psel in one step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // Ready, data and error are taken at the edge that samples ready
    @(posedge clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) begin
        error_cnt++;
        report_and_stop();
      end
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Holds a request for cyc edges, counts accepts, lets flags settle
  task automatic xfer(input logic w, input int cyc);
    acc = 0;
    // Requests change only just after a rising edge
    @(posedge clk);
    write_req <= w;
    read_req <= ~w;
    repeat (cyc + 4) begin
      @(negedge clk);
      acc += int'(w ? wacc : racc);
      if (--cyc == 0) begin
        @(posedge clk);
        write_req <= 1'b0;
        read_req <= 1'b0;
      end
    end
  endtask

  initial begin
    void'($urandom(20785));
    repeat (5) @(posedge clk);
    chk(32'({out_clr, ofr, af, ae}), 32'hE);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      ft = 1'($urandom);
      cs = 1'($urandom) & ~ft;
      brd.pulse(2'(i), ft, cs, 4'(i), 6);
      apb(1'b0, rscc_pkg::REG_CFG, 32'h0);
      chk(rd, ecfg(2'(i), ft, cs, 4'(i)));
      chk(32'({ftm, ww, rw}), 32'({ft, wdec(2'(i)), wdec(2'(i >> 2))}));
      apb(1'b0, rscc_pkg::REG_AE_OFS, 32'h0);
      chk(rd, 32'(preset(2'(i))));
      apb(1'b0, rscc_pkg::REG_AF_OFS, 32'h0);
      chk(rd, 32'(preset(2'(i))));
      chk(32'(ofr), 32'(!(ft | cs)));
      brd.wiggle();
      xfer(1'b0, 2);
      chk(32'(acc), 32'h0);
      apb(1'b0, rscc_pkg::REG_CFG, 32'h0);
      chk(rd, ecfg(2'(i), ft, cs, 4'(i)));
    end
    // Fill to the almost-full edge and past full in each output mode
    for (int j = 0; j < 3; j++) begin
      ft = (j == 1);
      cs = (j == 2);
      brd.pulse(2'h0, ft, cs, 4'($urandom), 6);
      xfer(1'b1, 1016);
      chk(32'({af, ae}), 32'h3);
      xfer(1'b1, 1);
      chk(32'(af), 32'h0);
      xfer(1'b1, 20);
      chk(32'(acc), 32'd7);
      chk(32'(ofr), 32'(ft | cs));
      apb(1'b0, rscc_pkg::REG_LEVEL, 32'h0);
      chk(rd, 32'h0009_0400);
    end
    xfer(1'b0, 5);
    chk(32'(acc), 32'd5);
    apb(1'b1, rscc_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'({wa, ra, ofr}), 32'(!(ft | cs)));
    apb(1'b1, rscc_pkg::REG_AE_OFS, 32'h2AA);
    apb(1'b0, rscc_pkg::REG_AE_OFS, 32'h0);
    chk(rd, 32'h2AA);
    apb(1'b1, rscc_pkg::REG_AF_OFS, 32'h155);
    apb(1'b0, rscc_pkg::REG_AF_OFS, 32'h0);
    chk(rd, 32'h155);
    apb(1'b0, 12'hFF0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, rscc_pkg::REG_CFG, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule // rscc_top_bench
